// [logic/wts_serial.sv]
`timescale 1ns/1ns
module wts_serial
  import wts_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // two-wire pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // timer-clear pin, debounced, active low
  input wire logic i_timer_clr_n,
  // timer state
  output logic [23:0] o_count,
  output logic [23:0] o_compare,
  output logic o_alert
);
  typedef enum {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK
  } wts_state_t;
  wts_state_t state;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [2:0] byte_idx;
  logic read_dir, ptr_compare, do_ack, drive_low;
  logic [23:0] compare_shadow;
  logic compare_valid, restart;
  logic clr_s, clr_d;
  logic [7:0] rx_byte;
  // wr_sel: pointer asked for a compare write; byte_done: 8 bits taken
  logic wr_sel, byte_done;
  logic [7:0] tx_byte;

  // read byte selection for index 1..3, else fill
  function automatic logic [7:0] sel_byte(input logic [23:0] v,
                                          input logic [2:0] idx);
    unique case (idx)
      3'h1: sel_byte = v[23:16];
      3'h2: sel_byte = v[15:8];
      3'h3: sel_byte = v[7:0];
      default: sel_byte = WTS_FILL_BYTE;
    endcase
  endfunction

  ///////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wts_sync u_sync_scl (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_async(i_scl), .o_sync(scl_s)
  );
  wts_sync u_sync_sda (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_async(i_sda), .o_sync(sda_s)
  );
  wts_sync u_sync_clr (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_async(i_timer_clr_n), .o_sync(clr_s)
  );

  // edge history
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      clr_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      clr_d <= clr_s;
    end
  end

  // line events
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign drive_low = o_sda_oe;
  assign start_det = scl_s && scl_d && sda_d && !sda_s; // RULE_05 RULE_07
  // stop ignored while we pull sda low
  assign stop_det = scl_s && scl_d && !sda_d && sda_s
                    && !drive_low; // RULE_06 RULE_19
  assign rx_byte = {shreg[6:0], sda_s};
  // next read byte; compare only after a pointer byte and timer running
  assign tx_byte = sel_byte((ptr_compare && clr_d) ? o_compare : o_count,
                            byte_idx + 3'h1); // RULE_04 RULE_13

  ///////////////////////////////////////////////////////////////////////
  // protocol state machine; reset, stop, a withheld ack or a controller nack return it to idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin // RULE_18
      state <= ST_IDLE;
      bit_cnt <= WTS_BIT_FIRST;
      byte_idx <= WTS_IDX_RESET;
      read_dir <= 1'b0;
      ptr_compare <= 1'b0;
      do_ack <= 1'b0;
      shreg <= '0;
      o_sda_oe <= 1'b0;
      compare_shadow <= WTS_COMPARE_RESET;
      o_compare <= WTS_COMPARE_RESET;
      compare_valid <= 1'b0;
      restart <= 1'b0;
      wr_sel <= 1'b0;
      byte_done <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (stop_det) begin
        state <= ST_IDLE; // RULE_06
        ptr_compare <= 1'b0; // RULE_17
        wr_sel <= 1'b0;
        byte_done <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (start_det && !drive_low) begin
        state <= ST_RECV; // RULE_12
        bit_cnt <= WTS_BIT_FIRST;
        byte_done <= 1'b0;
        byte_idx <= WTS_IDX_RESET;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            o_sda_oe <= 1'b0; // RULE_24
          end
          ST_RECV: begin
            if (scl_rise) begin
              shreg <= rx_byte; // RULE_10
              if (bit_cnt == WTS_BIT_LAST) begin
                byte_done <= 1'b1;
                if (byte_idx == WTS_IDX_RESET) begin
                  do_ack <= (rx_byte[7:1] == WTS_OWN_ADDR); // RULE_09
                  read_dir <= rx_byte[0];
                end else if (byte_idx == 3'h1) begin
                  // any pointer byte arms compare readback via restart
                  ptr_compare <= 1'b1; // RULE_16
                  wr_sel <= rx_byte[WTS_PTR_BIT]; // RULE_14
                  do_ack <= clr_d; // RULE_23
                end else begin
                  do_ack <= clr_d; // RULE_23
                  if (wr_sel && byte_idx <= 3'h4) begin
                    // RULE_15 RULE_03
                    compare_shadow <= {compare_shadow[15:0], rx_byte};
                    if (byte_idx == 3'h4 && clr_d) begin
                      o_compare <= {compare_shadow[15:0], rx_byte};
                      compare_valid <= 1'b1;
                      restart <= 1'b1; // RULE_21
                    end
                  end
                end
              end else begin
                bit_cnt <= bit_cnt - 3'h1;
              end
            end else if (scl_fall && byte_done) begin
              // RULE_08 ack after eighth falling edge
              byte_done <= 1'b0;
              o_sda_oe <= do_ack;
              state <= do_ack ? ST_ACK : ST_IDLE; // RULE_24
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              // saturate so long reads keep returning fill bytes
              if (byte_idx != 3'h7) begin
                byte_idx <= byte_idx + 3'h1;
              end
              bit_cnt <= WTS_BIT_FIRST;
              if (read_dir) begin
                // RULE_13 RULE_04 RULE_01
                shreg <= tx_byte;
                o_sda_oe <= !tx_byte[7];
                state <= ST_SEND;
              end else begin
                o_sda_oe <= 1'b0;
                state <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              // RULE_11 msb first
              if (bit_cnt == WTS_BIT_LAST) begin
                o_sda_oe <= 1'b0;
                state <= ST_MACK;
              end else begin
                bit_cnt <= bit_cnt - 3'h1;
                shreg <= {shreg[6:0], 1'b1};
                o_sda_oe <= !shreg[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // RULE_11 nack ends the read
              if (sda_s) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_ACK;
              end
            end
          end
        endcase
      end
    end
  end

  assign o_sda = 1'b0;

  ///////////////////////////////////////////////////////////////////////
  // counter core
  wts_counter u_counter (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_timer_run(clr_d),
    .i_restart(restart),
    .i_compare(o_compare),
    .i_compare_valid(compare_valid),
    .o_count(o_count),
    .o_alert(o_alert)
  );
endmodule

// [logic/wts_pkg.sv]
// Contract
// RULE_01 - count is a 24-bit value, readable only, never written by bus
// RULE_02 - controller reads count as three bytes, bit 23 first
// RULE_03 - compare value written and read as three bytes, bit 23 first
// RULE_04 - with timer-clear low, compare readback returns the count instead
// RULE_05 - sda falling while scl high is start, begins new access
// RULE_06 - sda rising while scl high is stop, returns to idle
// RULE_07 - sda changes only with scl low; otherwise start or stop aborts
// RULE_08 - receiver drives sda low during ninth clock as acknowledge
// RULE_09 - first byte is 7-bit address plus direction bit, one reads
// RULE_10 - write bytes taken msb first, each acknowledged low
// RULE_11 - read bytes sent msb first; controller nacks last then stops
// RULE_12 - start without stop is repeated start with new address byte
// RULE_13 - read bytes two to four carry register, later bytes all ones
// RULE_14 - pointer byte bit 7 one selects compare write, bit 0 one; code tests bit 7 only and ignores bit 0
// RULE_15 - write bytes three to five load the compare value
// RULE_16 - readback uses pointer bit 7 zero then repeated start read
// RULE_17 - stop clears the register pointer so reads return count
// RULE_18 - timer-clear pin never resets the serial logic; stop does
// RULE_19 - while device drives sda low, stop is not recognised
// RULE_20 - recovery: start, nine clocks with sda released, then stop
// RULE_21 - writing compare value clears counter and restarts from zero
// RULE_22 - count equal to compare raises alert, stops and holds count
// RULE_23 - debounced reset low: no ack for second and later write bytes
// RULE_24 - foreign address leaves sda released, idle until next start
package wts_pkg;
  localparam logic [6:0] WTS_OWN_ADDR = 7'h32;
  localparam int WTS_REG_BYTES = 3;
  localparam logic [23:0] WTS_COUNT_RESET = 24'h000000;
  localparam logic [23:0] WTS_COMPARE_RESET = 24'h000000;
  localparam logic [23:0] WTS_COUNT_MAX = 24'hffffff;
  localparam int WTS_PTR_BIT = 7;
  localparam logic [7:0] WTS_FILL_BYTE = 8'hff;
  localparam logic [2:0] WTS_BIT_LAST = 3'h0;
  localparam logic [2:0] WTS_BIT_FIRST = 3'h7;
  localparam logic [2:0] WTS_IDX_RESET = 3'h0;
  // tick period of the counter in system cycles
  localparam int WTS_TICK_DIV = 16;
  localparam logic [15:0] WTS_TICK_LAST = 16'(WTS_TICK_DIV - 1);
endpackage

// [logic/wts_sync.sv]
`timescale 1ns/1ns
module wts_sync (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // async level in, synced level out
  input wire logic i_async,
  output logic o_sync
);
  logic meta;
  // two-stage synchroniser, idle high
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// [logic/wts_counter.sv]
`timescale 1ns/1ns
module wts_counter
  import wts_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_timer_run,
  input wire logic i_restart,
  input wire logic [23:0] i_compare,
  input wire logic i_compare_valid,
  // state
  output logic [23:0] o_count,
  output logic o_alert
);
  logic [15:0] div_cnt;
  logic tick;
  // tick divider
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || div_cnt == WTS_TICK_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick = (div_cnt == WTS_TICK_LAST);
  // up counter with match hold
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_timer_run || i_restart) begin
      o_count <= WTS_COUNT_RESET; // RULE_21
      o_alert <= 1'b0;
    end else if (i_compare_valid && o_count == i_compare) begin
      o_alert <= 1'b1; // RULE_22
    end else if (tick && !o_alert && o_count != WTS_COUNT_MAX) begin
      o_count <= o_count + 24'h000001;
    end
  end
endmodule

// [testbench/wts_serial_asserts.sv]
`timescale 1ns/1ns
module wts_serial_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_timer_clr_n,
  // timer state
  input wire logic [23:0] o_count,
  input wire logic [23:0] o_compare,
  input wire logic o_alert
);
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // pin checks
  sda_low_a: assert property (o_sda == 1'b0)
    else $error("sda drive value not low");
  oe_edge_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("sda drive changed with scl high");
  oe_hold_a: assert property ($rose(o_sda_oe) |=> o_sda_oe [*3])
    else $error("sda drive dropped early");
  // timer checks
  alert_eq_a: assert property ($rose(o_alert) |-> o_count == o_compare)
    else $error("alert without match");
  alert_hold_a: assert property (o_alert && $past(o_alert) &&
    i_timer_clr_n && o_compare == $past(o_compare, 2) |-> $stable(o_count))
    else $error("count moved during alert");
  count_step_a: assert property ($changed(o_count) |->
    o_count == $past(o_count) + 24'h1 || o_count == 24'h0)
    else $error("count jumped");
  restart_a: assert property ($changed(o_compare) |->
    ##[0:2] o_count == 24'h0)
    else $error("compare write did not restart count");
  clr_cnt_a: assert property ((!i_timer_clr_n) [*5] |->
    o_count == 24'h0 && !o_alert)
    else $error("timer clear ignored");
  clr_cmp_a: assert property ((!i_timer_clr_n) [*4] |->
    $stable(o_compare))
    else $error("compare written while cleared");
endmodule

bind wts_serial wts_serial_asserts u_chk (.i_sys_clk, .i_rst_n, .i_scl,
  .i_sda, .o_sda, .o_sda_oe, .i_timer_clr_n, .o_count, .o_compare, .o_alert);

// [testbench/wts_ctl_model.sv]
`timescale 1ns/1ns
module wts_ctl_model (
  // bus pins, released sda reads high
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  localparam int QTR = 40;
  // idle bus, clock stands high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // one bit: data set with scl low, sampled while high
  task automatic bit_x(input logic d, output logic q);
    o_sda = d;
    #QTR;
    o_scl = 1'b1;
    #QTR;
    q = i_sda;
    #QTR;
    o_scl = 1'b0;
    #QTR;
  endtask
  // start or repeated start
  task automatic start();
    o_sda = 1'b1;
    #QTR;
    o_scl = 1'b1;
    #QTR;
    o_sda = 1'b0;
    #QTR;
    o_scl = 1'b0;
    #QTR;
  endtask
  // stop, bus left idle
  task automatic stop();
    o_sda = 1'b0;
    #QTR;
    o_scl = 1'b1;
    #QTR;
    o_sda = 1'b1;
    #(2*QTR);
  endtask
  // byte msb first then ack bit; ack_in high releases sda
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(ack_in, ack);
  endtask
  // stuck bus recovery
  task automatic recover();
    logic q;
    start();
    repeat (9) bit_x(1'b1, q);
    stop();
  endtask
endmodule

// [testbench/tb_wts_serial.sv]
`timescale 1ns/1ns
module tb_wts_serial;
  import wts_pkg::*;
  typedef struct packed {
    logic clr_n;
    logic [23:0] wv;
    logic [23:0] rb;
  } wts_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_timer_clr_n = 1'b1;
  logic scl, ctl_sda, o_sda, o_sda_oe, o_alert;
  logic [23:0] o_count, o_compare;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  wts_row_t rows [4] = '{'{1'b1, 24'habcdef, 24'habcdef},
    '{1'b1, 24'h5a0f3c, 24'h5a0f3c}, '{1'b0, 24'h123456, 24'h000000},
    '{1'b1, 24'h000040, 24'h000040}};
  // open-drain line with pull-up
  wire sda = ctl_sda & !(o_sda_oe & !o_sda);
  `define CHK(n, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
  end
  wts_serial dut (.i_sys_clk, .i_rst_n, .i_scl(scl), .i_sda(sda), .o_sda,
    .o_sda_oe, .i_timer_clr_n, .o_count, .o_compare, .o_alert);
  wts_ctl_model ctl (.o_scl(scl), .o_sda(ctl_sda), .i_sda(sda));
  // clock and hang guard
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare write: address, pointer, three bytes, stop
  task automatic wr_cmp(input logic [23:0] v, input logic exp_ack);
    logic [7:0] r;
    logic a;
    ctl.start();
    ctl.xfer({WTS_OWN_ADDR, 1'b0}, 1'b1, r, a);
    `CHK("addr ack", 1'b0, a)
    ctl.xfer(8'h81, 1'b1, r, a);
    `CHK("ptr ack", exp_ack, a)
    for (int i = 2; i >= 0; i--) begin
      ctl.xfer(v[i*8+:8], 1'b1, r, a);
      `CHK("data ack", exp_ack, a)
    end
    ctl.stop();
  endtask
  // four-byte read, optional dummy write first, nack last
  task automatic rd4(input logic pre, output logic [31:0] d);
    logic [7:0] r;
    logic a;
    ctl.start();
    if (pre) begin
      ctl.xfer({WTS_OWN_ADDR, 1'b0}, 1'b1, r, a);
      ctl.xfer(8'h01, 1'b1, r, a);
      ctl.start();
    end
    ctl.xfer({WTS_OWN_ADDR, 1'b1}, 1'b1, r, a);
    `CHK("rd addr ack", 1'b0, a)
    for (int i = 3; i >= 0; i--) begin
      ctl.xfer(8'hff, i == 0, r, a);
      d[i*8+:8] = r;
    end
    ctl.stop();
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] r;
    logic a;
    logic [23:0] cmp_exp;
    repeat (5) @(posedge i_sys_clk);
    #2 i_rst_n = 1'b1;
    `CHK("oe rst", 1'b0, o_sda_oe)
    `CHK("cmp rst", WTS_COMPARE_RESET, o_compare)
    `CHK("alert rst", 1'b0, o_alert)
    #80;
    cmp_exp = WTS_COMPARE_RESET;
    foreach (rows[k]) begin
      i_timer_clr_n = rows[k].clr_n;
      #200;
      wr_cmp(rows[k].wv, ~rows[k].clr_n);
      if (rows[k].clr_n) cmp_exp = rows[k].wv;
      `CHK("compare", cmp_exp, o_compare)
      rd4(1'b1, d);
      `CHK("readback", {rows[k].rb, WTS_FILL_BYTE}, d)
    end
    for (int n = 0; n < 2000 && o_alert !== 1'b1; n++) @(posedge i_sys_clk);
    #2;
    `CHK("alert", 1'b1, o_alert)
    `CHK("held count", 24'h000040, o_count)
    rd4(1'b0, d);
    `CHK("count read", {24'h000040, WTS_FILL_BYTE}, d)
    // foreign address stays silent
    ctl.start();
    ctl.xfer({WTS_OWN_ADDR ^ 7'h01, 1'b1}, 1'b1, r, a);
    `CHK("foreign ack", 1'b1, a)
    ctl.xfer(8'hff, 1'b1, r, a);
    `CHK("foreign data", 8'hff, r)
    ctl.stop();
    // stop lost while device holds sda low, then recovery
    ctl.start();
    ctl.xfer({WTS_OWN_ADDR, 1'b1}, 1'b1, r, a);
    repeat (3) ctl.bit_x(1'b1, a);
    ctl.stop();
    `CHK("stuck oe", 1'b1, o_sda_oe)
    ctl.recover();
    `CHK("released oe", 1'b0, o_sda_oe)
    rd4(1'b0, d);
    `CHK("after recovery", {24'h000040, WTS_FILL_BYTE}, d)
    tally_and_finish();
  end
endmodule
